// [design/lcc_cluster.sv]
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module lcc_cluster #(
  parameter int unsigned CLUSTER_IDX = 0,  // Position of this cluster in its row
  parameter int unsigned HALF_ROW    = 11  // Clusters in the first row half
) (
  input  wire  logic                                        pclk,
  input  wire  logic                                        presetn,
  input  wire  logic                                        psel,
  input  wire  logic                                        penable,
  input  wire  logic                                        pwrite,
  input  wire  logic [7:0]                                  paddr,
  input  wire  logic [31:0]                                 pwdata,
  output logic       [31:0]                                 prdata,
  output logic                                              pready,
  output logic                                              pslverr,
  input  wire  logic [lcc_pkg::NCELL-1:0][lcc_pkg::NDATA-1:0] cell_data,
  input  wire  logic [lcc_pkg::NGLOBAL-1:0]                 global_line,
  input  wire  logic                                        carry_in,
  input  wire  logic                                        cascade_in,
  output logic                                              carry_out,
  output logic                                              cascade_out,
  output logic       [lcc_pkg::NCELL-1:0]                   cell_out,
  output logic       [lcc_pkg::NLOCAL-1:0]                  local_right,
  output logic       [lcc_pkg::NLOCAL-1:0]                  local_left
);
  import lcc_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic lut_pick(input logic [LUT_W-1:0] mask, input logic [3:0] idx);
    lut_pick = mask[idx];
  endfunction : lut_pick

  function automatic logic ff_next(input lcc_ff_e ty, input logic q, input logic f,
                                   input logic k);
    case (ty)
      LCC_FF_T:  ff_next = q ^ f;
      LCC_FF_JK: ff_next = (f & ~q) | (~k & q);
      LCC_FF_SR: ff_next = f | (~k & q);
      default:   ff_next = f;
    endcase
  endfunction : ff_next

  // ****************************************************************
  // Configuration registers and APB slave
  // ****************************************************************
  lcc_cfg_s             cfg_q [NCELL];
  logic [CTRL_W-1:0]    ctrl_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [NCELL-1:0]     reg_q;
  logic [NCELL-1:0]     out_w;
  logic                 wr_en;
  logic                 setup;
  logic [3:0]           cell_sel;
  logic                 hit_cell;

  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pready_q & pwrite;
  assign cell_sel = paddr[5:2];
  assign hit_cell = (paddr[1:0] == 2'b00) && (paddr <= ADDR_LAST);

  // No wait state: answer prepared in setup, seen in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (setup)
      begin
        if (hit_cell)
        begin
          prdata_q <= {{(32-CFG_W){1'b0}}, cfg_q[cell_sel]};
        end
        else if (paddr == ADDR_CTRL)
        begin
          prdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
        end
        else if (paddr == ADDR_STATUS)
        begin
          prdata_q <= {6'h00, out_w, 6'h00, reg_q};
        end
        else
        begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NCELL; i++)
      begin
        cfg_q[i] <= CFG_RESET;
      end
      ctrl_q <= CTRL_RESET;
    end
    else if (wr_en)
    begin
      if (hit_cell)
      begin
        cfg_q[cell_sel] <= lcc_cfg_s'(pwdata[CFG_W-1:0]);
      end
      else if (paddr == ADDR_CTRL)
      begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // Cluster control signals
  // ****************************************************************
  logic [NGLOBAL-1:0] glob_meta_q;
  logic [NGLOBAL-1:0] glob_q;
  lcc_ctl_s           ctl;
  logic               clk_prev_q;
  logic               tick;

  // Global lines arrive from pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      glob_meta_q <= '0;
      glob_q      <= '0;
    end
    else
    begin
      glob_meta_q <= global_line;
      glob_q      <= glob_meta_q;
    end
  end

  always_comb
  begin
    if (ctrl_q[CTRL_FROM_CELL1])
    begin
      ctl.clk   = cell_data[0][CTL_CLK];
      ctl.aclr  = cell_data[0][CTL_ACLR];
      ctl.sclr  = cell_data[0][CTL_SCLR];
      ctl.sload = cell_data[0][CTL_SLD];
    end
    else
    begin
      ctl.clk   = glob_q[ctrl_q[CTRL_CLK_LSB +: 2]];
      ctl.aclr  = ctrl_q[CTRL_ACLR_EN] & glob_q[ctrl_q[CTRL_ACLR_LSB +: 2]];
      ctl.sclr  = 1'b0;
      ctl.sload = 1'b0;
    end
  end

  // Cell clock is a sampled edge of the chosen source; pclk must outrun it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= ctl.clk;
    end
  end

  assign tick = ctl.clk & ~clk_prev_q;

  // ****************************************************************
  // Cell datapath with carry and cascade chains
  // ****************************************************************
  logic             chain_head;
  logic [NCELL-1:0] lut_w;
  logic [NCELL-1:0] cin_w;
  logic [NCELL-1:0] cout_w;
  logic [NCELL-1:0] casc_w;
  logic [NCELL-1:0] byp_w;
  logic [NCELL-1:0] nxt_w;

  // Links come from the cluster two positions back; none at a row or half start
  assign chain_head = (CLUSTER_IDX < 2) || (CLUSTER_IDX == HALF_ROW)
                      || (CLUSTER_IDX == HALF_ROW + 1);

  always_comb
  begin
    logic        c;
    logic        k;
    logic [3:0]  d;
    logic [2:0]  i3;
    logic        l;
    d  = 4'h0;
    i3 = 3'b000;
    l  = 1'b0;
    c = chain_head ? 1'b0 : carry_in;
    k = chain_head ? ~cfg_q[1].casc_or : cascade_in;
    for (int i = 0; i < NCELL; i++)
    begin
      d = cell_data[i];
      if (i == 0)
      begin
        cin_w[i] = 1'b0;
      end
      else if ((i == CHAIN_CELL) && cfg_q[i].fb)
      begin
        cin_w[i] = reg_q[i];
      end
      else
      begin
        cin_w[i] = c;
      end
      case (cfg_q[i].mode)
        LCC_ARITH:
        begin
          i3        = {cin_w[i], d[1], d[0]};
          lut_w[i]  = lut_pick(cfg_q[i].lut, {1'b0, i3});
          cout_w[i] = lut_pick(cfg_q[i].lut, {1'b1, i3});
        end
        LCC_COUNTER:
        begin
          i3        = {cin_w[i], d[1], reg_q[i]};
          lut_w[i]  = lut_pick(cfg_q[i].lut, {1'b0, i3});
          cout_w[i] = lut_pick(cfg_q[i].lut, {1'b1, i3});
        end
        default:
        begin
          i3        = 3'b000;
          lut_w[i]  = lut_pick(cfg_q[i].lut,
                               {d[3], cfg_q[i].csel ? cin_w[i] : d[2], d[1], d[0]});
          cout_w[i] = cin_w[i];
        end
      endcase
      l = lut_w[i];
      if ((i != 0) && cfg_q[i].casc_en)
      begin
        l = cfg_q[i].casc_or ? ~(~l & ~k) : (l & k);
      end
      casc_w[i] = l;
      byp_w[i]  = cfg_q[i].byp | (cfg_q[i].casc_en & cfg_q[i].casc_or);
      nxt_w[i]  = ff_next(cfg_q[i].ff, reg_q[i], l, d[3]);
      if (i != 0)
      begin
        c = cout_w[i];
        k = casc_w[i];
      end
    end
  end

  // ****************************************************************
  // Cell flipflops
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reg_q <= '0;
    end
    else
    begin
      for (int i = 0; i < NCELL; i++)
      begin
        if (ctl.aclr)
        begin
          reg_q[i] <= 1'b0;
        end
        else if (tick)
        begin
          if (ctl.sclr)
          begin
            reg_q[i] <= 1'b0;
          end
          else if (ctl.sload)
          begin
            reg_q[i] <= cell_data[i][2];
          end
          else if ((cfg_q[i].mode == LCC_COUNTER) && (i != CHAIN_CELL) && !cell_data[i][0])
          begin
            reg_q[i] <= reg_q[i];
          end
          else if (!byp_w[i])
          begin
            reg_q[i] <= nxt_w[i];
          end
        end
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NCELL; i++)
    begin
      out_w[i] = byp_w[i] ? casc_w[i] : reg_q[i];
    end
  end

  // ****************************************************************
  // Routing outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_out    <= '0;
      local_right <= '0;
      local_left  <= '0;
      carry_out   <= 1'b0;
      cascade_out <= 1'b0;
    end
    else
    begin
      cell_out    <= out_w;
      local_right <= out_w[NLOCAL-1:0];
      local_left  <= out_w[NCELL-1:NLOCAL];
      carry_out   <= cout_w[NCELL-1];
      cascade_out <= casc_w[NCELL-1];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_both_sync;
    tick && ctl.sclr && ctl.sload && !ctl.aclr;
  endsequence

  AST_SCLR_OVER_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    s_both_sync |=> (reg_q == '0))
    else $error("sync clear lost to sync load");
  AST_HOLD_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !ctl.aclr) |=> $stable(reg_q))
    else $error("cell register changed without a cell clock");
  AST_ACLR: assert property (@(posedge pclk) disable iff (!presetn)
    ctl.aclr |=> (reg_q == '0))
    else $error("cluster clear missed");
  AST_FIRST_NO_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    cin_w[0] == 1'b0)
    else $error("first cell saw a carry");
  AST_FEEDBACK: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[CHAIN_CELL].fb |-> (cin_w[CHAIN_CELL] == reg_q[CHAIN_CELL]))
    else $error("feedback mux not driving carry-in");
  AST_HALF_HEAD: assert property (@(posedge pclk) disable iff (!presetn)
    (chain_head && !cfg_q[CHAIN_CELL].fb) |-> (cin_w[CHAIN_CELL] == 1'b0))
    else $error("carry crossed a chain head");
  AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (cell_out == $past(out_w)) && ((byp_w & (out_w ^ casc_w)) == '0))
    else $error("bypassed cell output mismatch");
  AST_OR_NO_REG: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q[9].casc_en && cfg_q[9].casc_or) |-> ##1 (cell_out[9] == $past(casc_w[9])))
    else $error("OR cascade used the flipflop");
  AST_LOCAL_NETS: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ({local_left, local_right} == $past(out_w)))
    else $error("local networks do not carry cell outputs");
  AST_CELL1_CTL: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[CTRL_FROM_CELL1] |-> (ctl.sclr == cell_data[0][CTL_SCLR]))
    else $error("first cell not driving cluster controls");

endmodule : lcc_cluster

// [design/lcc_pkg.sv]
package lcc_pkg;

  // ****************************************************************
  // Cluster geometry
  // ****************************************************************
  localparam int unsigned NCELL      = 10;
  localparam int unsigned NDATA      = 4;
  localparam int unsigned NGLOBAL    = 4;
  localparam int unsigned LUT_W      = 16;
  localparam int unsigned CHAIN_CELL = 1;   // Second cell, owns the feedback mux
  localparam int unsigned NLOCAL     = 5;   // Cells driving each local network

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CELL0  = 8'h00; // Ten cell words, one per cell
  localparam logic [7:0] ADDR_CTRL   = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam logic [7:0] ADDR_LAST   = 8'h24;

  // Control register fields
  localparam int unsigned CTRL_FROM_CELL1 = 0;
  localparam int unsigned CTRL_CLK_LSB    = 1;
  localparam int unsigned CTRL_ACLR_LSB   = 3;
  localparam int unsigned CTRL_ACLR_EN    = 5;
  localparam int unsigned CTRL_W          = 6;
  localparam logic [5:0]  CTRL_RESET      = 6'h00;

  // Status register fields
  localparam int unsigned STAT_REG_LSB = 0;
  localparam int unsigned STAT_OUT_LSB = 16;

  // Cell input roles when the first cell drives the cluster controls
  localparam int unsigned CTL_CLK  = 0;
  localparam int unsigned CTL_ACLR = 1;
  localparam int unsigned CTL_SCLR = 2;
  localparam int unsigned CTL_SLD  = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {LCC_NORMAL, LCC_ARITH, LCC_COUNTER, LCC_RSVD} lcc_mode_e;
  typedef enum logic [1:0] {LCC_FF_D, LCC_FF_T, LCC_FF_JK, LCC_FF_SR} lcc_ff_e;

  typedef struct packed {
    logic              fb;       // Register feedback onto carry-in
    logic              casc_or;  // Cascade combines by OR
    logic              casc_en;  // Join the cascade chain
    logic              csel;     // Carry-in replaces third data input
    logic              byp;      // Combinational, flipflop bypassed
    lcc_ff_e           ff;
    lcc_mode_e         mode;
    logic [LUT_W-1:0]  lut;
  } lcc_cfg_s;

  localparam int unsigned CFG_W = $bits(lcc_cfg_s);
  localparam lcc_cfg_s    CFG_RESET = '{fb: 1'b0, casc_or: 1'b0, casc_en: 1'b0,
                                        csel: 1'b0, byp: 1'b1, ff: LCC_FF_D,
                                        mode: LCC_NORMAL, lut: 16'h0000};

  typedef struct packed {
    logic clk;
    logic aclr;
    logic sclr;
    logic sload;
  } lcc_ctl_s;

endpackage : lcc_pkg

// [tb/lcc_nbr_model.sv]
`timescale 1ns/1ps
module lcc_nbr_model (
  input  wire logic                  pclk,
  input  wire logic [9:0][3:0]       data_req,
  input  wire logic [3:0]            glob_req,
  output logic      [9:0][3:0]       cell_data,
  output logic      [3:0]            global_line,
  output logic                       carry_in,
  output logic                       cascade_in
);
  // ****************************************************************
  // Neighbouring cells and pins, launched on the shared clock
  // ****************************************************************
  logic [9:0][3:0] data_q = '0;
  logic [3:0]      glob_q = 4'h0;
  logic [1:0]      tog_q  = 2'h1;

  always_ff @(posedge pclk)
  begin
    data_q <= data_req;
    glob_q <= glob_req;
  end

  // No chain feeds a head cluster: never a settled level here
  always_ff @(posedge pclk)
  begin
    tog_q <= tog_q + 2'h1;
  end

  assign cell_data   = data_q;
  assign global_line = glob_q;
  assign carry_in    = tog_q[0];
  assign cascade_in  = tog_q[1];
endmodule : lcc_nbr_model

// [tb/lcc_cluster_bench.sv]
`timescale 1ns/1ps
module lcc_cluster_bench;
  import lcc_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic            carry_in, cascade_in, carry_out, cascade_out;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [9:0][3:0] data_req, cell_data;
  logic [3:0]      glob_req, global_line;
  logic [9:0]      cell_out, ex;
  logic [4:0]      local_right, local_left;
  lcc_cfg_s        c;
  logic [15:0]     m [10];
  logic [9:0]      sa, sb;
  int              fails, checks;

  lcc_cluster lcc_cluster_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_data(cell_data),
    .global_line(global_line), .carry_in(carry_in), .cascade_in(cascade_in),
    .carry_out(carry_out), .cascade_out(cascade_out), .cell_out(cell_out),
    .local_right(local_right), .local_left(local_left));

  lcc_nbr_model lcc_nbr_model_inst (.pclk(pclk), .data_req(data_req),
    .glob_req(glob_req), .cell_data(cell_data), .global_line(global_line),
    .carry_in(carry_in), .cascade_in(cascade_in));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Entered just after a rising edge; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n == 50)
      fails++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic setc(input int i);
    apb(1'b1, 8'(4 * i), 32'(c));
  endtask : setc

  // Pulse of the clock input of cell 0, with sync clear and load levels
  task automatic cpulse(input logic sclr, input logic sld);
    data_req[0] <= {sld, sclr, 2'b01};
    cyc(8);
    data_req[0] <= {sld, sclr, 2'b00};
    cyc(8);
  endtask : cpulse

  task automatic gpulse(input int k);
    glob_req[k] <= 1'b1;
    cyc(8);
    glob_req[k] <= 1'b0;
    cyc(8);
  endtask : gpulse

  function automatic logic lut(input logic [15:0] mask, input logic [3:0] idx);
    return mask[idx];
  endfunction : lut

  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial
  begin
    #100us;
    fails++;
    conclude();
  end

  initial
  begin
    fails = 0;
    checks = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    data_req = '0;
    glob_req = '0;
    void'($urandom(32'h51c2));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("cfg reset", rd, 32'(CFG_RESET));
    end
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'(CTRL_RESET));
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Random lookup functions, combinational cells, cell 1 takes carry-in
    repeat (4)
    begin
      for (int i = 0; i < 10; i++)
      begin
        m[i] = 16'($urandom);
        c = '{fb: 1'b0, casc_or: 1'b0, casc_en: 1'b0, csel: (i == 1), byp: 1'b1,
              ff: LCC_FF_D, mode: LCC_NORMAL, lut: m[i]};
        setc(i);
        data_req[i] <= 4'($urandom);
      end
      cyc(4);
      for (int i = 0; i < 10; i++)
        ex[i] = lut(m[i], (i == 1) ? (data_req[i] & 4'hb) : data_req[i]);
      chk("lut out", 32'(cell_out), 32'(ex));
      chk("local right", 32'(local_right), 32'(ex[4:0]));
      chk("local left", 32'(local_left), 32'(ex[9:5]));
    end
    // Flipflops on global clock line 0: D in cell 2, T in cell 3
    apb(1'b1, ADDR_CTRL, 32'h0);
    c = '{fb: 1'b0, casc_or: 1'b0, casc_en: 1'b0, csel: 1'b0, byp: 1'b0,
          ff: LCC_FF_D, mode: LCC_NORMAL, lut: 16'hffff};
    setc(2);
    c.ff = LCC_FF_T;
    setc(3);
    // Cell 1 inverts its own register through the feedback path
    c = '{fb: 1'b1, casc_or: 1'b0, casc_en: 1'b0, csel: 1'b1, byp: 1'b0,
          ff: LCC_FF_D, mode: LCC_NORMAL, lut: 16'h0f0f};
    setc(1);
    gpulse(1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("unselected clock", 32'(rd[3:1]), 32'h0);
    gpulse(0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ff first edge", 32'(rd[3:1]), 32'h7);
    gpulse(0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ff second edge", 32'(rd[3:1]), 32'h2);
    // Global clear on line 1, clock still on line 0
    apb(1'b1, ADDR_CTRL, 32'h28);
    gpulse(1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("global clear", 32'(rd[3:1]), 32'h0);
    // Cell 0 idle first, else a stale level hides the first control edge
    data_req[0] <= 4'h0;
    // Controls from cell 0: load, then clear and load together
    apb(1'b1, ADDR_CTRL, 32'h1);
    c = '{fb: 1'b0, casc_or: 1'b0, casc_en: 1'b0, csel: 1'b0, byp: 1'b0,
          ff: LCC_FF_D, mode: LCC_COUNTER, lut: 16'h0000};
    for (int i = 1; i < 10; i++)
    begin
      setc(i);
      data_req[i] <= 4'h5;
    end
    cpulse(1'b0, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("sync load", 32'(rd[9:1]), 32'h1ff);
    // Enable low: cells 2..9 hold, cell 1 ignores it and takes its table
    for (int i = 1; i < 10; i++)
      data_req[i] <= 4'h4;
    cpulse(1'b0, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("count enable", 32'(rd[9:1]), 32'h1fe);
    cpulse(1'b1, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("clear over load", 32'(rd[9:1]), 32'h0);
    // Nine-bit adder in cells 1..9, final carry on carry_out
    apb(1'b1, ADDR_CTRL, 32'h0);
    c = '{fb: 1'b0, casc_or: 1'b0, casc_en: 1'b0, csel: 1'b0, byp: 1'b1,
          ff: LCC_FF_D, mode: LCC_ARITH, lut: 16'he896};
    for (int i = 1; i < 10; i++)
      setc(i);
    for (int t = 0; t < 6; t++)
    begin
      sa = (t == 0) ? 10'h1ff : 10'($urandom) & 10'h1ff;
      sb = (t == 0) ? 10'h001 : 10'($urandom) & 10'h1ff;
      data_req[0] <= 4'($urandom);
      for (int i = 1; i < 10; i++)
        data_req[i] <= {2'b00, sb[i-1], sa[i-1]};
      cyc(5);
      chk("adder", 32'({carry_out, cell_out[9:1]}), 32'(sa + sb));
    end
    // Cascade chain over cells 1..9, AND then OR
    for (int t = 0; t < 6; t++)
    begin
      ex[0] = (t >= 3);
      ex[1] = ~ex[0];
      for (int i = 1; i < 10; i++)
      begin
        m[i] = (t % 3 == 0) ? ~16'h0001 : 16'($urandom);
        c = '{fb: 1'b0, casc_or: ex[0], casc_en: 1'b1, csel: 1'b0, byp: 1'b1,
              ff: LCC_FF_D, mode: LCC_NORMAL, lut: m[i]};
        setc(i);
        data_req[i] <= (t % 3 == 0) ? 4'h5 : 4'($urandom);
      end
      cyc(4);
      for (int i = 1; i < 10; i++)
        ex[1] = ex[0] ? (ex[1] | lut(m[i], data_req[i])) : (ex[1] & lut(m[i], data_req[i]));
      chk("cascade", 32'(cascade_out), 32'(ex[1]));
    end
    conclude();
  end
endmodule : lcc_cluster_bench
